// ==== src/efs_delay_timer.sv ====
// Trip and release timing for one stage, fixed or inverse characteristic
`timescale 1ns/100ps
module efs_delay_timer import efs_pkg::*; (
    input wire logic ref_clk, // System clock
    input wire logic resetn, // Async reset
    input wire logic cycle_tick, // Program cycle pulse
    input wire logic run, // Start active
    input wire logic inverse, // Inverse delay mode
    input wire logic [TW-1:0] delay, // Delay or time multiplier, ticks
    input wire logic [TW-1:0] release_time, // Release delay, ticks
    input wire logic [RW-1:0] ratio, // Current to threshold, 0.01 units
    output logic done, // Operating time reached
    output logic [TW-1:0] remaining, // Ticks left to trip
    output logic [TW-1:0] expected // Expected operating time
);
    logic [TW-1:0] elapsed;
    logic [TW-1:0] rel_cnt;
    wire [RW-1:0] excess = (ratio > RATIO_ONE) ? ratio - RATIO_ONE : 17'h00001;
    wire [TW+6:0] scaled = {7'h00, delay} * {19'h00000, PCT_SCALE};
    wire [TW+6:0] inv_raw = scaled / {9'h000, excess};
    // Follows the present current every cycle, so a changing fault moves the target
    wire [TW-1:0] inv_time = (inv_raw > {7'h00, TIME_MAX}) ? TIME_MAX : inv_raw[TW-1:0];
    wire [TW-1:0] rel_next = rel_cnt + 19'h00001;

    assign expected = inverse ? inv_time : delay;
    assign done = run && (elapsed >= expected);
    assign remaining = (run && expected > elapsed) ? expected - elapsed : '0;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            elapsed <= '0;
            rel_cnt <= '0;
        end else if (cycle_tick) begin
            if (run) begin
                elapsed <= (elapsed == TIME_MAX) ? elapsed : elapsed + 19'h00001;
                rel_cnt <= '0;
            end else if (elapsed != '0) begin
                // Elapsed time survives a short dropout until the release time runs out
                if (rel_next >= release_time) begin
                    elapsed <= '0;
                    rel_cnt <= '0;
                end else begin
                    rel_cnt <= rel_next;
                end
            end
        end
    end
endmodule

// ==== src/efs_history.sv ====
// Circular store of the newest operation records of one stage
`timescale 1ns/100ps
module efs_history import efs_pkg::*; #(
    parameter int DEPTH = HIST_DEPTH
) (
    input wire logic ref_clk, // System clock
    input wire logic resetn, // Async reset
    input wire logic wr, // Store record
    input wire efs_rec_s rec, // Record to store
    input wire logic [3:0] rd_idx, // 0 is newest
    output efs_rec_s rd_rec // Selected record
);
    efs_rec_s mem [DEPTH];
    logic [3:0] wptr;
    wire [4:0] back = {1'b0, wptr} + 5'(DEPTH - 1) - {1'b0, rd_idx};
    wire [4:0] pos = (back >= 5'(DEPTH)) ? back - 5'(DEPTH) : back;

    assign rd_rec = (rd_idx < 4'(DEPTH)) ? mem[pos[3:0]] : '0;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wptr <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                mem[k] <= '0;
            end
        end else if (wr) begin
            mem[wptr] <= rec;
            wptr <= (wptr == 4'(DEPTH - 1)) ? 4'h0 : wptr + 4'h1;
        end
    end
endmodule

// ==== src/efs_pkg.sv ====
// Shared constants, register map and types for the earth fault stage block
package efs_pkg;
    localparam int NSTAGE = 4;
    localparam int HIST_DEPTH = 12;
    localparam int TW = 19;
    localparam int CW = 16;
    localparam int RW = 17;
    localparam int HW = 13;
    localparam int AW = 17;
    // One cycle tick is one program cycle of 5 ms; all stage times count ticks
    localparam int TICK_MS = 5;
    localparam logic [TW-1:0] TIME_MAX = 19'h57e40;
    localparam logic [6:0] PCT_SCALE = 7'h64;
    localparam logic [6:0] RELEASE_PCT = 7'h61;
    localparam logic [RW-1:0] RATIO_ONE = 17'h00064;
    localparam logic [RW-1:0] RATIO_MAX = 17'h1e848;
    localparam logic [HW-1:0] HARM_LIMIT_MAX = 13'h1388;
    // Stage register offsets, stage n at byte base n * 0x40
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_PICKUP = 6'h04;
    localparam logic [5:0] OFS_DELAY = 6'h08;
    localparam logic [5:0] OFS_RELEASE = 6'h0c;
    localparam logic [5:0] OFS_HARM_LIMIT = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h14;
    localparam logic [5:0] OFS_REMAIN = 6'h18;
    localparam logic [5:0] OFS_EXPECT = 6'h1c;
    localparam logic [5:0] OFS_RATIO = 6'h20;
    localparam logic [5:0] OFS_CNT_START = 6'h24;
    localparam logic [5:0] OFS_CNT_TRIP = 6'h28;
    localparam logic [5:0] OFS_CNT_BLOCK = 6'h2c;
    localparam logic [5:0] OFS_CNT_CLEAR = 6'h30;
    // Global register offsets inside the 0x100 page
    localparam logic [7:0] GOFS_CTRL = 8'h00;
    localparam logic [7:0] GOFS_ANGLE = 8'h04;
    localparam logic [7:0] GOFS_HIST_SEL = 8'h08;
    localparam logic [7:0] GOFS_HIST_STAMP = 8'h0c;
    localparam logic [7:0] GOFS_HIST_INFO = 8'h10;
    localparam logic [7:0] GOFS_HIST_REMAIN = 8'h14;
    localparam logic [7:0] GOFS_TIMESTAMP = 8'h18;
    // Stage control fields
    localparam int CTRL_INVERSE = 0;
    localparam int CTRL_INRUSH = 1;
    localparam int CTRL_EVT_ON = 2;
    localparam int CTRL_EVT_OFF = 3;
    localparam int CTRL_LN_LSB = 4;
    localparam logic [6:0] CTRL_RESET = 7'h0c;
    localparam logic [CW-1:0] PICKUP_RESET = 16'h04b0;
    localparam logic [TW-1:0] DELAY_RESET = 19'h00014;
    localparam logic [TW-1:0] RELEASE_RESET = 19'h00000;
    localparam logic [HW-1:0] HARM_LIMIT_RESET = 13'h0001;

    typedef enum logic [1:0] {EFS_NORMAL, EFS_START, EFS_TRIP, EFS_BLOCKED} efs_cond_e;
    typedef enum logic [2:0] {LN_ON, LN_BLOCKED, LN_TEST, LN_TEST_BLOCKED, LN_OFF} efs_ln_e;
    typedef enum logic [1:0] {EV_START, EV_TRIP, EV_BLOCK} efs_kind_e;

    typedef struct packed {
        logic [1:0] stage;
        efs_kind_e kind;
        logic on;
        logic [31:0] stamp;
    } efs_event_s;

    typedef struct packed {
        logic [31:0] stamp;
        efs_kind_e kind;
        logic [2:0] fault;
        logic [CW-1:0] current;
        logic [TW-1:0] remain;
        logic [2:0] group;
    } efs_rec_s;
endpackage

// ==== src/efs_stage_logic.sv ====
// Four earth fault stages with APB registers, events, counters and history
`timescale 1ns/100ps
module efs_stage_logic import efs_pkg::*; (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire logic cycle_tick, // One pulse per 5 ms program cycle
    input wire logic [CW-1:0] residual_current, // Measured magnitude
    input wire logic [HW-1:0] harm_ratio, // 2nd harmonic ratio, 0.01 %
    input wire logic signed [AW-1:0] residual_angle, // Absolute angle, 0.01 deg
    input wire logic signed [AW-1:0] ref_v_angle, // Pos. seq. voltage angle
    input wire logic signed [AW-1:0] ref_i_angle, // Pos. seq. current angle
    input wire logic voltage_present, // Phase voltages available
    input wire logic [2:0] fault_code, // Detected fault type code
    input wire logic [2:0] setting_group, // Active setting group
    input wire logic [NSTAGE-1:0] ext_block, // Blocking matrix inputs
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [NSTAGE-1:0] start_out, // Stage start
    output logic [NSTAGE-1:0] trip_out, // Stage trip, held off in test modes
    output logic [NSTAGE-1:0] blocked_out, // Stage blocked
    output logic event_valid, // Event strobe
    output efs_event_s event_data // Event content
);
    localparam int NEV = NSTAGE * 6;

    logic [31:0] tstamp;
    logic node_mode_en;
    logic [5:0] hist_sel;
    logic [NEV-1:0] pend;
    logic [NEV-1:0] pend_set;
    logic [NEV-1:0] pend_clr;
    int sel;
    logic [31:0] stage_rd [NSTAGE];
    logic [31:0] stage_stamp [NSTAGE];
    efs_rec_s hist_rd [NSTAGE];

    // Bus decode
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire stage_page = (paddr[11:8] == 4'h0) && (paddr[5:0] <= OFS_CNT_CLEAR);
    wire glob_page = (paddr[11:8] == 4'h1) && (paddr[7:0] <= GOFS_TIMESTAMP);
    wire addr_hit = (stage_page || glob_page) && (paddr[1:0] == 2'b00);
    wire [1:0] st_idx = paddr[7:6];
    wire [5:0] st_ofs = paddr[5:0];
    wire gwr = wr_en && addr_hit && glob_page;
    wire [AW-1:0] ref_angle = voltage_present ? ref_v_angle : ref_i_angle;
    wire [AW:0] angle = {residual_angle[AW-1], residual_angle}
        - {ref_angle[AW-1], ref_angle};
    efs_rec_s hist_pick;
    assign hist_pick = hist_rd[hist_sel[5:4]];
    wire [31:0] glob_rd =
        (paddr[7:0] == GOFS_CTRL) ? {31'h0, node_mode_en} :
        (paddr[7:0] == GOFS_ANGLE) ? {{(31 - AW){angle[AW]}}, angle} :
        (paddr[7:0] == GOFS_HIST_SEL) ? {26'h0, hist_sel} :
        (paddr[7:0] == GOFS_HIST_STAMP) ? hist_pick.stamp :
        (paddr[7:0] == GOFS_HIST_INFO) ? {hist_pick.current, 6'h0, hist_pick.kind,
            1'b0, hist_pick.fault, 1'b0, hist_pick.group} :
        (paddr[7:0] == GOFS_HIST_REMAIN) ? {13'h0, hist_pick.remain} :
        tstamp;
    wire [31:0] rd_mux = !addr_hit ? 32'h0 : stage_page ? stage_rd[st_idx] : glob_rd;

    assign pready = 1'b1;

    // Read data captured in the setup cycle so it comes from a flop, zero wait
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
            pslverr <= !addr_hit;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            node_mode_en <= 1'b0;
            hist_sel <= '0;
            tstamp <= '0;
        end else begin
            if (cycle_tick) begin
                tstamp <= tstamp + 32'h1;
            end
            if (gwr && paddr[7:0] == GOFS_CTRL) begin
                node_mode_en <= pwdata[0];
            end
            if (gwr && paddr[7:0] == GOFS_HIST_SEL) begin
                hist_sel <= pwdata[5:0];
            end
        end
    end

    generate
        for (genvar i = 0; i < NSTAGE; i++) begin : g_stage
            logic [6:0] ctrl;
            logic [CW-1:0] pickup_threshold;
            logic [TW-1:0] delay;
            logic [TW-1:0] release_time;
            logic [HW-1:0] harm_limit;
            logic [15:0] cnt [3];
            logic pick;
            logic blk_sample;
            logic start;
            logic trip;
            logic blocked;
            logic [2:0] prev_fault;
            logic [31:0] chg_stamp;
            logic tmr_done;
            logic [TW-1:0] remain;
            logic [TW-1:0] expect_time;
            efs_rec_s rec;

            wire swr = wr_en && addr_hit && stage_page && (st_idx == 2'(i));
            efs_ln_e ln_set;
            assign ln_set = efs_ln_e'(ctrl[CTRL_LN_LSB +: 3]);
            efs_ln_e ln;
            assign ln = node_mode_en ? ln_set : LN_ON;
            wire mode_blk = (ln == LN_BLOCKED) || (ln == LN_TEST_BLOCKED);
            wire mode_off = (ln == LN_OFF);
            wire mode_test = (ln == LN_TEST) || (ln == LN_TEST_BLOCKED);
            wire inrush_blk = ctrl[CTRL_INRUSH] && (harm_ratio > harm_limit);
            wire blk_now = ext_block[i] || inrush_blk || mode_blk;
            wire [23:0] cur_x100 = {8'h00, residual_current} * {17'h0, PCT_SCALE};
            wire [23:0] thr_x97 = {8'h00, pickup_threshold} * {17'h0, RELEASE_PCT};
            wire over = residual_current > pickup_threshold;
            wire under = cur_x100 < thr_x97;
            wire next_pick = pick ? !under : over;
            wire [23:0] ratio_raw = (pickup_threshold == '0) ? 24'hffffff :
                cur_x100 / {8'h00, pickup_threshold};
            wire [RW-1:0] ratio = (ratio_raw > {7'h00, RATIO_MAX}) ? RATIO_MAX :
                ratio_raw[RW-1:0];
            wire next_start = next_pick && !blk_now && !mode_off;
            wire next_blocked = next_pick && blk_now && !mode_off;
            wire next_trip = next_start && (trip || tmr_done);
            wire [2:0] cur_st = {blocked, trip, start};
            wire [2:0] nxt_st = {next_blocked, next_trip, next_start};
            wire [2:0] rise = cycle_tick ? (nxt_st & ~cur_st) : 3'h0;
            wire [2:0] fall = cycle_tick ? (cur_st & ~nxt_st) : 3'h0;
            wire [1:0] evt_sel = {ctrl[CTRL_EVT_OFF], ctrl[CTRL_EVT_ON]};
            efs_cond_e cond;
            assign cond = trip ? EFS_TRIP : start ? EFS_START :
                blocked ? EFS_BLOCKED : EFS_NORMAL;
            wire [2:0] ln_show = node_mode_en ? ln_set : 3'h0;
            wire [31:0] rd =
                (st_ofs == OFS_CTRL) ? {25'h0, ctrl} :
                (st_ofs == OFS_PICKUP) ? {16'h0, pickup_threshold} :
                (st_ofs == OFS_DELAY) ? {13'h0, delay} :
                (st_ofs == OFS_RELEASE) ? {13'h0, release_time} :
                (st_ofs == OFS_HARM_LIMIT) ? {19'h0, harm_limit} :
                (st_ofs == OFS_STATUS) ? {23'h0, blk_sample, prev_fault, ln_show, cond} :
                (st_ofs == OFS_REMAIN) ? {13'h0, remain} :
                (st_ofs == OFS_EXPECT) ? {13'h0, expect_time} :
                (st_ofs == OFS_RATIO) ? {15'h0, ratio} :
                (st_ofs == OFS_CNT_START) ? {16'h0, cnt[EV_START]} :
                (st_ofs == OFS_CNT_TRIP) ? {16'h0, cnt[EV_TRIP]} :
                (st_ofs == OFS_CNT_BLOCK) ? {16'h0, cnt[EV_BLOCK]} : 32'h0;
            wire [HW-1:0] lim_wr = (pwdata[HW-1:0] > HARM_LIMIT_MAX) ? HARM_LIMIT_MAX :
                (pwdata[HW-1:0] == '0) ? HARM_LIMIT_RESET : pwdata[HW-1:0];

            assign stage_rd[i] = rd;
            assign stage_stamp[i] = chg_stamp;
            // Bit pairs per kind: on edge, then off edge
            assign pend_set[i*6 +: 6] = {fall[2], rise[2], fall[1], rise[1], fall[0], rise[0]}
                & {3{evt_sel}};
            assign start_out[i] = start;
            assign blocked_out[i] = blocked;
            // Test modes exercise the stage but keep the trip off the outside world
            assign trip_out[i] = trip && !mode_test;

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    ctrl <= CTRL_RESET;
                    pickup_threshold <= PICKUP_RESET;
                    delay <= DELAY_RESET;
                    release_time <= RELEASE_RESET;
                    harm_limit <= HARM_LIMIT_RESET;
                end else if (swr) begin
                    if (st_ofs == OFS_CTRL) ctrl <= pwdata[6:0];
                    if (st_ofs == OFS_PICKUP) pickup_threshold <= pwdata[CW-1:0];
                    if (st_ofs == OFS_DELAY) delay <= pwdata[TW-1:0];
                    if (st_ofs == OFS_RELEASE) release_time <= pwdata[TW-1:0];
                    if (st_ofs == OFS_HARM_LIMIT) harm_limit <= lim_wr;
                end
            end

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    pick <= 1'b0;
                    blk_sample <= 1'b0;
                    start <= 1'b0;
                    trip <= 1'b0;
                    blocked <= 1'b0;
                    prev_fault <= '0;
                    chg_stamp <= '0;
                end else if (cycle_tick) begin
                    blk_sample <= blk_now;
                    pick <= next_pick;
                    start <= next_start;
                    trip <= next_trip;
                    blocked <= next_blocked;
                    if (rise[EV_TRIP]) prev_fault <= fault_code;
                    if ((rise | fall) != 3'h0) chg_stamp <= tstamp;
                end
            end

            // A clear in the same cycle as an increment restarts the count at 1
            for (genvar k = 0; k < 3; k++) begin : g_cnt
                wire clr = swr && (st_ofs == OFS_CNT_CLEAR) && pwdata[k];
                always_ff @(posedge ref_clk or negedge resetn) begin
                    if (!resetn) begin
                        cnt[k] <= '0;
                    end else if (rise[k]) begin
                        cnt[k] <= clr ? 16'h0001 : cnt[k] + 16'h0001;
                    end else if (clr) begin
                        cnt[k] <= '0;
                    end
                end
            end

            efs_delay_timer u_timer (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .cycle_tick(cycle_tick),
                .run(start),
                .inverse(ctrl[CTRL_INVERSE]),
                .delay(delay),
                .release_time(release_time),
                .ratio(ratio),
                .done(tmr_done),
                .remaining(remain),
                .expected(expect_time)
            );

            assign rec.stamp = tstamp;
            assign rec.kind = rise[EV_TRIP] ? EV_TRIP : rise[EV_START] ? EV_START : EV_BLOCK;
            assign rec.fault = fault_code;
            assign rec.current = residual_current;
            assign rec.remain = remain;
            assign rec.group = setting_group;

            efs_history u_hist (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .wr(rise != 3'h0),
                .rec(rec),
                .rd_idx(hist_sel[3:0]),
                .rd_rec(hist_rd[i])
            );
        end
    endgenerate

    // Lowest pending event goes out first, one per clock
    always_comb begin
        sel = 0;
        for (int j = NEV - 1; j >= 0; j--) begin
            if (pend[j]) sel = j;
        end
    end

    assign pend_clr = (pend != '0) ? (NEV'(1) << sel) : '0;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend <= '0;
            event_valid <= 1'b0;
            event_data <= '0;
        end else begin
            pend <= (pend & ~pend_clr) | pend_set;
            event_valid <= (pend != '0);
            if (pend != '0) begin
                event_data.stage <= 2'(sel / 6);
                event_data.kind <= efs_kind_e'(2'((sel % 6) / 2));
                event_data.on <= ((sel % 2) == 0);
                event_data.stamp <= stage_stamp[2'(sel / 6)];
            end
        end
    end
endmodule

// ==== tb/efs_meas_model.sv ====
// Measurement and blocking matrix model driving one stage block
`timescale 1ns/100ps
module efs_meas_model import efs_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic resetn, // Async reset
    input wire logic [CW-1:0] cur_req, // Wanted current level
    input wire logic [NSTAGE-1:0] blk_req, // Wanted block levels
    output logic cycle_tick, // Short program cycle pulse
    output logic [CW-1:0] residual_current, // Measured magnitude
    output logic [NSTAGE-1:0] ext_block // Blocking matrix lines
);
    logic [3:0] cnt;
    // Cycle shortened to 16 clocks to keep the run brief
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            cycle_tick <= 1'b0;
            residual_current <= '0;
            ext_block <= '0;
        end else begin
            cnt <= cnt + 4'h1;
            cycle_tick <= (cnt == 4'hf);
            residual_current <= cur_req;
            ext_block <= blk_req;
        end
    end
endmodule

// ==== tb/efs_stage_checker.sv ====
// Port level assertions for the earth fault stage block
`timescale 1ns/100ps
module efs_stage_checker import efs_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic cycle_tick, // Tick
    input wire logic [NSTAGE-1:0] ext_block, // Block in
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic [11:0] paddr, // APB address
    input wire logic pslverr, // APB error
    input wire logic [NSTAGE-1:0] start_out, // Start
    input wire logic [NSTAGE-1:0] trip_out, // Trip
    input wire logic [NSTAGE-1:0] blocked_out, // Blocked
    input wire logic event_valid, // Event strobe
    input wire efs_event_s event_data // Event
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_NO_BOTH: assert property ((start_out & blocked_out) == 4'h0)
        else $error("start and blocked together");
    AST_TRIP_BLK: assert property ((trip_out & blocked_out) == 4'h0)
        else $error("trip while blocked");
    AST_TICK: assert property (!$past(cycle_tick) |-> $stable(start_out) && $stable(blocked_out))
        else $error("stage output moved off tick");
    AST_BLK_START: assert property ($past(cycle_tick) |-> (start_out & $past(ext_block)) == 4'h0)
        else $error("start despite block");
    AST_TRIP_PRE: assert property ($past(cycle_tick)
        |-> (trip_out & ~$past(trip_out) & ~$past(start_out)) == 4'h0)
        else $error("trip without prior start");
    AST_EVT: assert property ($rose(start_out[0]) |-> ##1 event_valid && event_data.stage == 2'h0
        && event_data.kind == EV_START && event_data.on)
        else $error("missing start on event");
    AST_EVT_KIND: assert property (event_valid |-> event_data.kind != 2'h3)
        else $error("bad event kind");
    AST_ERR: assert property (psel && !penable && paddr == 12'h200 |=> pslverr)
        else $error("unmapped access not refused");
endmodule

// ==== tb/tb.sv ====
// Register level tests of the earth fault stage block
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb import efs_pkg::*;;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, tick;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rv;
    logic [CW-1:0] cur_req = '0, cur;
    logic [NSTAGE-1:0] blk_req = '0, blk, start_out, trip_out, blocked_out;
    logic [HW-1:0] harm = '0;
    logic [2:0] fcode = 3'h1;
    logic event_valid;
    efs_event_s event_data;
    int num_errors = 0, compares = 0;
    always #12.5 ref_clk = ~ref_clk;
    efs_meas_model MDL (.ref_clk(ref_clk), .resetn(resetn), .cur_req(cur_req),
        .blk_req(blk_req), .cycle_tick(tick), .residual_current(cur), .ext_block(blk));
    efs_stage_logic DUT (.ref_clk(ref_clk), .resetn(resetn), .cycle_tick(tick),
        .residual_current(cur), .harm_ratio(harm), .residual_angle(17'sh0),
        .ref_v_angle(17'sh0), .ref_i_angle(17'sh0), .voltage_present(1'b0),
        .fault_code(fcode), .setting_group(3'h2), .ext_block(blk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out),
        .blocked_out(blocked_out), .event_valid(event_valid), .event_data(event_data));
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a following call never reassigns psel in this step
        @(posedge ref_clk);
    endtask
    task automatic ticks(input int n);
        repeat (n * 16) @(posedge ref_clk);
    endtask
    task automatic end_sim;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        acc(0, 12'h000, 0); `CHK(rv, 32'h0000000c)
        acc(0, 12'h004, 0); `CHK(rv, 32'h000004b0)
        acc(0, 12'h008, 0); `CHK(rv, 32'h00000014)
        acc(0, 12'h010, 0); `CHK(rv, 32'h00000001)
        acc(1, 12'h010, 32'h1fff); acc(0, 12'h010, 0); `CHK(rv, 32'h00001388)
        acc(1, 12'h010, 32'h1); acc(0, 12'h200, 0); `CHK({pslverr, rv}, {1'b1, 32'h0})
        acc(1, 12'h008, 32'h3);
        fcode <= 3'h4;
        cur_req <= 16'h0600; ticks(2); `CHK(start_out[0], 1'b1)
        acc(0, 12'h014, 0); `CHK(rv[1:0], 2'h1)
        ticks(5); `CHK(trip_out[0], 1'b1)
        acc(0, 12'h014, 0); `CHK(rv[1:0], 2'h2)
        `CHK(rv[7:5], 3'h4)
        cur_req <= 16'h0498; ticks(2); `CHK(start_out[0], 1'b1)
        cur_req <= 16'h0480; ticks(2); `CHK({start_out[0], trip_out[0]}, 2'h0)
        acc(0, 12'h024, 0); `CHK(rv, 32'h1)
        acc(0, 12'h028, 0); `CHK(rv, 32'h1)
        blk_req <= 4'h2; cur_req <= 16'h0600; ticks(2);
        `CHK({start_out[1], blocked_out[1], start_out[0]}, 3'b011)
        blk_req <= 4'h3; ticks(2); `CHK({start_out[0], blocked_out[0]}, 2'b01)
        acc(0, 12'h06c, 0); `CHK(rv, 32'h1)
        acc(1, 12'h070, 32'h7); acc(0, 12'h06c, 0); `CHK(rv, 32'h0)
        acc(1, 12'h080, 32'h0e); harm <= 13'h0064; ticks(2);
        `CHK({start_out[2], blocked_out[2]}, 2'b01)
        harm <= 13'h0000; ticks(2); `CHK({start_out[2], blocked_out[2]}, 2'b10)
        acc(1, 12'h108, 32'h0); acc(0, 12'h110, 0); `CHK({rv[9:8], rv[2:0]}, 5'h12)
        // 1536 against 1200 is 1.28, held in 0.01 units
        acc(0, 12'h020, 0);
        `CHK(rv, 32'h00000080)
        // Stage 3 in test mode: hidden until the global enable is set
        acc(1, 12'h0c0, 32'h2c);
        acc(0, 12'h0d4, 0);
        `CHK(rv[4:0], 5'h01)
        acc(1, 12'h100, 32'h1);
        acc(0, 12'h0d4, 0);
        `CHK(rv[4:0], 5'h09)
        end_sim;
    end
endmodule
bind efs_stage_logic efs_stage_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
    .cycle_tick(cycle_tick), .ext_block(ext_block), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .event_valid(event_valid), .event_data(event_data));
